// *** rtl/sync_pkg.sv ***
// Constants for the sync source selection block
package sync_pkg;
	// Register byte offsets
	localparam logic [7:0] ctrl_offset = 8'h00;
	localparam logic [7:0] rate_offset = 8'h04;
	localparam logic [7:0] state_offset = 8'h08;
	localparam logic [7:0] ref_offset = 8'h0c;
	localparam logic [7:0] freq_offset = 8'h10;
	// Control fields
	localparam int ctrl_auto_bit = 0;
	localparam int ctrl_pref_lsb = 1;
	localparam logic [2:0] ctrl_reset = 3'h0;
	localparam logic [7:0] rate_reset = 8'h30;
	// Source codes, also scan order
	localparam logic [1:0] src_none = 2'h0;
	localparam logic [1:0] src_wck = 2'h1;
	localparam logic [1:0] src_adat = 2'h2;
	localparam logic [1:0] src_spdif = 2'h3;
	localparam int num_inputs = 3;
	// Per-input report codes
	localparam logic [1:0] st_no_lock = 2'h0;
	localparam logic [1:0] st_lock = 2'h1;
	localparam logic [1:0] st_sync = 2'h2;
	// Accepted rate window in kHz
	localparam logic [7:0] rate_min_khz = 8'd28;
	localparam logic [7:0] rate_max_khz = 8'd200;
	// Double rate band in kHz (88.2 reads as 88)
	localparam logic [7:0] double_min_khz = 8'd88;
	localparam logic [7:0] double_max_khz = 8'd96;
	// Measurement gate: count of frame edges in 1 ms gives kHz
	localparam int gate_us = 1000;
	localparam int clk_mhz = 10;
	localparam int gate_cycles = gate_us * clk_mhz;
	// Slot pairing
	localparam int slot_bits = 3;
	localparam int sample_bits = 24;
	// AXI responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// *** rtl/sync_source_selection.sv ***
// Clock reference selection, input status reporting and double rate slot pairing
`timescale 1ns/1ps

// Behaviour
// - In automatic mode every digital input is checked continuously for valid signal.
// - Automatic mode runs slave from input whose rate matches playback rate.
// - Master mode runs from internal oscillator only and reports master.
// - All inputs receive together; at most one becomes clock reference.
// - Without preference, first valid input found becomes the reference.
// - Valid preferred source is used; otherwise remaining inputs are scanned in turn. The code first keeps a current reference that is still valid.
// - No valid input forces master clock from internal oscillator.
// - Report active reference input and its measured frequency.
// - Each input reports no lock, lock, or lock and synchronous.
// - Any input rate from 28 to 200 kHz is accepted and followed.
// - At 88.2 or 96 kHz ADAT runs paired at half the rate.
// - Paired mode puts channel n in slots 2n-1 and 2n; four channels.
// - Candidates are word clock, ADAT and SPDIF inputs.
module sync_source_selection #(
	parameter int gate_len = sync_pkg::gate_cycles
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Recovery loop pins: bit 0 word clock, 1 ADAT, 2 SPDIF
	input wire logic [2:0] lock_pin,
	input wire logic [2:0] frame_pin,
	// Clock steering
	output logic [1:0] clock_select,
	output logic slave_mode,
	output logic double_rate_slot_pairing,
	// ADAT slot stream on the link clock
	input wire logic adat_clk,
	input wire logic slot_valid,
	input wire logic [2:0] slot_num,
	input wire logic [23:0] slot_data,
	output logic ch_valid,
	output logic [2:0] ch_num,
	output logic ch_phase,
	output logic [23:0] ch_data
);
	localparam int n = sync_pkg::num_inputs;

	// Overview of the state held below:
	// - control and system rate written by software over the register bus
	// - per input a frame edge counter and the last complete measurement
	// - the active reference and the clock steering outputs
	// - a small slot remapper running on the link clock
	// Everything on aclk stops while ce is low; the link side follows two
	// link clocks later because ce crosses as a level.

	logic [2:0] ctrl;
	logic [7:0] sys_rate;
	logic [2:0] lock_s1, lock_s2, frame_s1, frame_s2, frame_s3;
	logic [7:0] edge_cnt [n];
	logic [7:0] freq [n];
	logic [15:0] gate_cnt;
	logic [1:0] active_ref;
	logic [1:0] input_state [n];
	logic [n-1:0] valid, synced;
	logic [7:0] eff_rate [n];

	wire automatic_clock_follow = ctrl[sync_pkg::ctrl_auto_bit];
	wire [1:0] pref = ctrl[sync_pkg::ctrl_pref_lsb +: 2];
	wire gate_end = (gate_cnt == 16'(gate_len - 1));
	wire pairing = (sys_rate >= sync_pkg::double_min_khz) && (sys_rate <= sync_pkg::double_max_khz);

	// Pin synchronisers; third stage only feeds edge detection
	// Lock and frame pins come from recovery loops on foreign clocks, so
	// nothing before the second stage is read by logic. The frame clocks must
	// stay below half of aclk or edges will be missed and the rate reads low.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_s1 <= 3'h0;
			lock_s2 <= 3'h0;
			frame_s1 <= 3'h0;
			frame_s2 <= 3'h0;
			frame_s3 <= 3'h0;
		end else if (ce) begin
			lock_s1 <= lock_pin;
			lock_s2 <= lock_s1;
			frame_s1 <= frame_pin;
			frame_s2 <= frame_s1;
			frame_s3 <= frame_s2;
		end
	end

	// Common measurement gate, one millisecond so edges count in kHz
	// One gate serves all inputs; a shorter gate speeds up tests but
	// coarsens the reading to one count per gate length.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_cnt <= 16'h0;
		end else if (ce) begin
			gate_cnt <= gate_end ? 16'h0 : gate_cnt + 16'h1;
		end
	end

	// Per-input rate measurement and status, kept running in both modes
	// The status is reported in master mode as well, so a user can see
	// whether an input would be usable before switching to automatic.
	// A measurement lags the pin by up to one full gate.
	genvar gi;
	generate
		for (gi = 0; gi < n; gi++) begin : g_in
			wire rise = frame_s2[gi] && !frame_s3[gi];
			wire [7:0] next_cnt = (edge_cnt[gi] == 8'hff) ? 8'hff : edge_cnt[gi] + 8'h1;
			// Saturating count keeps an overspeed input out of the window
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					edge_cnt[gi] <= 8'h0;
					freq[gi] <= 8'h0;
				end else if (ce) begin
					if (gate_end) begin
						freq[gi] <= rise ? next_cnt : edge_cnt[gi];
						edge_cnt[gi] <= 8'h0;
					end else if (rise) begin
						edge_cnt[gi] <= next_cnt;
					end
				end
			end
			// Paired ADAT frames run at half the system rate
			assign eff_rate[gi] = (gi == 1 && pairing) ? {freq[gi][6:0], 1'b0} : freq[gi];
			// Lock alone is not enough: the rate must sit in the followable window
			assign valid[gi] = lock_s2[gi] && (freq[gi] >= sync_pkg::rate_min_khz)
				&& (freq[gi] <= sync_pkg::rate_max_khz);
			assign synced[gi] = valid[gi] && (eff_rate[gi] == sys_rate);
			assign input_state[gi] = synced[gi] ? sync_pkg::st_sync
				: (valid[gi] ? sync_pkg::st_lock : sync_pkg::st_no_lock);
		end
	endgenerate

	// Reference choice: preference first, else hold the current one, else scan after the preference
	// Holding the current reference avoids hopping between two valid inputs
	// whenever a measurement edge falls differently; the scan loop runs
	// backwards so that the first candidate after the preference wins.
	// Manual mode leaves no reference at all, which forces master below.
	logic [1:0] next_ref;
	always_comb begin
		logic [1:0] cand;
		cand = sync_pkg::src_none;
		next_ref = sync_pkg::src_none;
		if (automatic_clock_follow) begin
			if (pref != sync_pkg::src_none && valid[pref - 2'h1]) begin
				next_ref = pref;
			end else if (active_ref != sync_pkg::src_none && valid[active_ref - 2'h1]) begin
				next_ref = active_ref;
			end else begin
				// Scan from the input after the preference, word clock first without one
				for (int k = n; k >= 1; k--) begin
					cand = 2'(((32'(pref) + 32'(k) - 1) % n) + 1);
					if (valid[cand - 2'h1]) begin
						next_ref = cand;
					end
				end
			end
		end
	end

	// Only a reference matching the playback rate may drive the sample clock
	wire ref_synced = (active_ref != sync_pkg::src_none) && synced[active_ref - 2'h1];
	wire [7:0] ref_freq = (active_ref == sync_pkg::src_none) ? 8'h0 : freq[active_ref - 2'h1];

	// Clock steering outputs
	// Steering trails the reference by one cycle so the select and the
	// slave flag always change together and never glitch against each other.
	// A reference that is valid but off rate is reported, yet not followed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_ref <= sync_pkg::src_none;
			clock_select <= sync_pkg::src_none;
			slave_mode <= 1'b0;
			double_rate_slot_pairing <= 1'b0;
		end else if (ce) begin
			active_ref <= next_ref;
			clock_select <= ref_synced ? active_ref : sync_pkg::src_none;
			slave_mode <= ref_synced;
			double_rate_slot_pairing <= pairing;
		end
	end

	// AXI4-Lite write: address and data taken in either order, response after both
	// Each channel is held in its own register once taken, so a master that
	// offers data before the address is served as well as the reverse.
	// Both readies drop while a response waits, which keeps one write in flight.
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_held || aw_take;
	wire w_have = w_held || w_take;
	wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_go = aw_have && w_have && !s_axi_bvalid;
	wire wr_ctrl = wr_go && (wr_addr == sync_pkg::ctrl_offset);
	wire wr_rate = wr_go && (wr_addr == sync_pkg::rate_offset);
	wire wr_ok = wr_ctrl || wr_rate;

	// Write channel holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (ce) begin
			aw_held <= aw_have && !wr_go;
			w_held <= w_have && !wr_go;
			if (aw_take) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Write response and control registers; status registers refuse writes
	// Only the low byte lane matters, since both writable fields fit in it.
	// A new rate takes effect on the status in the cycle after the write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sync_pkg::resp_okay;
			ctrl <= sync_pkg::ctrl_reset;
			sys_rate <= sync_pkg::rate_reset;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? sync_pkg::resp_okay : sync_pkg::resp_slverr;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_ctrl && wr_strb[0]) begin
				ctrl <= wr_data[2:0];
			end
			if (wr_rate && wr_strb[0]) begin
				sys_rate <= wr_data[7:0];
			end
		end
	end

	// AXI4-Lite read decode
	// Status words are assembled from live values; a read may therefore see
	// a measurement that changes in the very next cycle.
	// Unmapped offsets answer with an error and a zero word.
	wire [31:0] rd_state = {26'h0, input_state[2], input_state[1], input_state[0]};
	wire [31:0] rd_ref = {16'h0, ref_freq, 4'h0, pairing, slave_mode, active_ref};
	wire [31:0] rd_freq = {8'h0, freq[2], freq[1], freq[0]};
	wire rd_hit_ctrl = (s_axi_araddr == sync_pkg::ctrl_offset);
	wire rd_hit_rate = (s_axi_araddr == sync_pkg::rate_offset);
	wire rd_hit_state = (s_axi_araddr == sync_pkg::state_offset);
	wire rd_hit_ref = (s_axi_araddr == sync_pkg::ref_offset);
	wire rd_hit_freq = (s_axi_araddr == sync_pkg::freq_offset);
	wire rd_hit = rd_hit_ctrl || rd_hit_rate || rd_hit_state || rd_hit_ref || rd_hit_freq;
	wire [31:0] rd_word = rd_hit_ctrl ? {29'h0, ctrl}
		: rd_hit_rate ? {24'h0, sys_rate}
		: rd_hit_state ? rd_state
		: rd_hit_ref ? rd_ref
		: rd_hit_freq ? rd_freq : 32'h0;
	assign s_axi_arready = !s_axi_rvalid;

	// Read data captured at the address handshake
	// Capturing here keeps the data stable while the master stalls rready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= sync_pkg::resp_okay;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? sync_pkg::resp_okay : sync_pkg::resp_slverr;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Link domain: reset, clock enable and pairing mode cross as levels through two flops
	// All three are slow levels, so a plain two flop synchroniser suffices.
	// The link clock must run during reset or the link outputs stay unknown.
	// A pairing change reaches the mapper two link clocks late; slots in
	// that window use the old mapping, which software avoids by changing
	// the rate only while the stream is idle.
	logic [1:0] lrst_sync, lce_sync, lpair_sync;
	wire lrst_n = lrst_sync[1];
	wire lce = lce_sync[1];
	wire lpair = lpair_sync[1];
	always_ff @(posedge adat_clk) begin
		lrst_sync <= {lrst_sync[0], aresetn};
		lce_sync <= {lce_sync[0], ce};
		lpair_sync <= {lpair_sync[0], double_rate_slot_pairing};
	end

	// Slot to channel mapping; paired mode halves the slot number
	wire [2:0] map_num = lpair ? {1'b0, slot_num[2:1]} : slot_num;
	wire map_phase = lpair && slot_num[0];

	// Registered channel stream on the link clock
	// Number, phase and data hold their last value between valid words.
	always_ff @(posedge adat_clk) begin
		if (!lrst_n) begin
			ch_valid <= 1'b0;
			ch_num <= 3'h0;
			ch_phase <= 1'b0;
			ch_data <= 24'h0;
		end else if (lce) begin
			ch_valid <= slot_valid;
			if (slot_valid) begin
				ch_num <= map_num;
				ch_phase <= map_phase;
				ch_data <= slot_data;
			end
		end
	end
endmodule

// *** tb/audio_source_model.sv ***
// Far-side model: lock and recovered frame clocks of the three digital inputs
`timescale 1ns/1ps
module audio_source_model (
	input wire logic [2:0] on,
	input wire logic [2:0] slow,
	output logic [2:0] lock_pin,
	output logic [2:0] frame_pin
);
	// All inputs share one external master, so lock simply follows presence
	assign lock_pin = on;
	// Period 200 ns gives 50 edges per short gate, 400 ns gives 25, below the window
	for (genvar i = 0; i < 3; i++) begin : g_in
		initial begin
			frame_pin[i] = 1'b0;
			#(17 + 23 * i);
			forever begin
				frame_pin[i] = ~frame_pin[i];
				#(slow[i] ? 200 : 100);
			end
		end
	end
endmodule

// *** tb/sync_source_selection_monitor.sv ***
// Port checker for the sync source selection block
`timescale 1ns/1ps
module sync_source_selection_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] clock_select,
	input wire logic slave_mode,
	input wire logic adat_clk,
	input wire logic slot_valid,
	input wire logic ch_valid,
	input wire logic ch_phase
);
	// Steering and reference status must never disagree
	a_master_osc: assert property (@(posedge aclk) disable iff (!aresetn)
		!slave_mode |-> clock_select == sync_pkg::src_none) else $error("master without oscillator");
	a_one_source: assert property (@(posedge aclk) disable iff (!aresetn)
		slave_mode |-> clock_select != sync_pkg::src_none) else $error("slave with no source");
	a_reset_master: assert property (@(posedge aclk)
		!aresetn |=> clock_select == sync_pkg::src_none && !slave_mode) else $error("reset not master");
	// Register bus handshake
	a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");
	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("no write response");
	a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("no read data");
	a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	// Link side: each slot yields exactly one channel word a cycle later
	a_slot_out: assert property (@(posedge adat_clk) disable iff (!aresetn)
		slot_valid |=> ch_valid) else $error("slot lost");
	a_ch_cause: assert property (@(posedge adat_clk) disable iff (!aresetn)
		ch_valid |-> $past(slot_valid)) else $error("channel word without slot");
	c_slave: cover property (@(posedge aclk) $rose(slave_mode));
	c_slverr: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bresp == sync_pkg::resp_slverr);
	c_paired: cover property (@(posedge adat_clk) ch_valid && ch_phase);
endmodule

bind sync_source_selection sync_source_selection_monitor u_mon (.*);

// *** tb/sync_source_selection_tb.sv ***
// Self-checking bench for the sync source selection block
`timescale 1ns/1ps
module sync_source_selection_tb;
	logic aclk = 1'b0, adat_clk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, clock_select;
	logic [2:0] lock_pin, frame_pin, on = 3'h7, slow = 3'h0, slot_num = 3'h0, ch_num;
	logic slave_mode, double_rate_slot_pairing, slot_valid = 1'b0, ch_valid, ch_phase;
	logic [23:0] slot_data = 24'h0, ch_data;
	int err_total = 0, checked = 0;

	sync_source_selection #(.gate_len(100)) dut (.*);
	audio_source_model u_src (.*);

	// Link clock period 160 ns, free of any phase tie to aclk
	always #50 aclk = ~aclk;
	always #80 adat_clk = ~adat_clk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Ready is sampled mid-cycle so the release after the edge never races the design
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = sync_pkg::resp_okay);
		logic aw, w, b;
		logic [1:0] rs;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		// Ends once bvalid is seen; a lost response is left to the watchdog
		forever begin
			@(negedge aclk);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) w = 1'b0;
			b = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
			if (b) break;
		end
		s_axi_bready <= 1'b0;
		check(b, 1'b1);
		check(rs, er);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = sync_pkg::resp_okay);
		logic ar, r;
		logic [31:0] d;
		logic [1:0] rs;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ar = 1'b1;
		r = 1'b0;
		forever begin
			@(negedge aclk);
			if (s_axi_arready) ar = 1'b0;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			s_axi_arvalid <= ar;
			if (r) break;
		end
		s_axi_rready <= 1'b0;
		check(d, ed);
		check(rs, er);
	endtask

	// Selection waits span two measurement gates, so the bound is generous
	task wait_sel(input logic [1:0] s, input logic sl);
		repeat (400) begin
			@(negedge aclk);
			if (clock_select === s && slave_mode === sl) break;
		end
		check(clock_select, s);
		check(slave_mode, sl);
	endtask

	// Released slot data is inverted so stale values cannot pass
	task slot(input logic [2:0] n, input logic [2:0] en, input logic ep);
		@(posedge adat_clk);
		slot_valid <= 1'b1;
		slot_num <= n;
		slot_data <= {21'h0a5000, n};
		@(posedge adat_clk);
		slot_valid <= 1'b0;
		slot_data <= ~{21'h0a5000, n};
		#1;
		check(ch_valid, 1'b1);
		check(ch_num, en);
		check(ch_phase, ep);
		check(ch_data, {21'h0a5000, n});
	endtask

	task end_sim;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#2_000_000;
		err_total++;
		end_sim;
	end

	// Reset spans 2 cycles; the link side catches it through its own two flops
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h30);
		rd(8'h14, 32'h0, sync_pkg::resp_slverr);
		wr(8'h08, 32'h3, sync_pkg::resp_slverr);
		wr(8'h04, 32'h32);
		repeat (300) @(posedge aclk);
		rd(8'h08, 32'h2a);
		wr(8'h04, 32'h30);
		repeat (20) @(posedge aclk);
		rd(8'h08, 32'h15);
		wr(8'h04, 32'h32);
		wr(8'h00, 32'h1);
		wait_sel(2'h1, 1'b1);
		rd(8'h0c, 32'h3205);
		rd(8'h10, 32'h323232);
		wr(8'h00, 32'h0);
		wait_sel(2'h0, 1'b0);
		wr(8'h00, 32'h5);
		wait_sel(2'h2, 1'b1);
		@(posedge aclk);
		on[1] <= 1'b0;
		wait_sel(2'h3, 1'b1);
		@(posedge aclk);
		slow[2] <= 1'b1;
		wait_sel(2'h1, 1'b1);
		rd(8'h08, 32'h02);
		@(posedge aclk);
		on <= 3'h0;
		wait_sel(2'h0, 1'b0);
		wr(8'h04, 32'h60);
		repeat (5) @(posedge aclk);
		check(double_rate_slot_pairing, 1'b1);
		repeat (5) @(posedge adat_clk);
		for (int n = 0; n < 8; n++) slot(n[2:0], n[3:1], n[0]);
		wr(8'h04, 32'h32);
		repeat (20) @(posedge aclk);
		check(double_rate_slot_pairing, 1'b0);
		slot(3'h5, 3'h5, 1'b0);
		end_sim;
	end
endmodule
